/* core/fts_regs.svh */
// Purpose: Constants for the flow-through synchronous SRAM port
// Assumes: Included by its bare name
// Notes: Widths, depths, burst and reset values, and timing figures only
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH

// ----------------------------------------------------------------
// Organisation
// ----------------------------------------------------------------
`define FTS_ADDR_W 20
`define FTS_ADDR36_W 19
`define FTS_DATA_W 36
`define FTS_HALF_W 18
`define FTS_LANE_W 9
`define FTS_LANES 4
`define FTS_LO_DEPTH 1048576
`define FTS_HI_DEPTH 524288

// ----------------------------------------------------------------
// Burst counter
// ----------------------------------------------------------------
`define FTS_BURST_W 2
`define FTS_BURST_START 2'h0
`define FTS_BURST_ONE 2'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FTS_ADDR_RST 20'h00000
`define FTS_BW_RST 4'hf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FTS_CLK_PERIOD_NS 8
`define FTS_WDATA_LAG_CYC 1

`endif

/* core/fts_pkg.sv */
// Purpose: Types shared by the SRAM port files
// Assumes: fts_regs.svh holds all numbers
// Notes: None
`default_nettype none
`include "fts_regs.svh"

package fts_pkg;

    // ------------------------------------------------------------
    // Operation in the current access cycle
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FTS_OP_IDLE,
        FTS_OP_READ,
        FTS_OP_WRITE
    } fts_op_t;

    // ------------------------------------------------------------
    // One sampled request from the pins
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [`FTS_ADDR_W-1:0] addr;
        logic we_n;
        logic [`FTS_LANES-1:0] bw_n;
        logic load;
        logic sel;
    } fts_req_t;

    // ------------------------------------------------------------
    // Access state held between qualified edges
    // ------------------------------------------------------------
    typedef struct packed
    {
        fts_op_t op;
        logic [`FTS_ADDR_W-1:0] base;
        logic [`FTS_LANES-1:0] bw_n;
    } fts_acc_t;

endpackage

`default_nettype wire

/* core/fts_burst_ctr.sv */
// Purpose: Two-bit burst counter with linear or interleaved order
// Assumes: step and load are already qualified by the clock qualify
// Notes: Offset is combinational from the held start and count
`default_nettype none
`include "fts_regs.svh"

module fts_burst_ctr
    import fts_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic linear,
    input wire logic [`FTS_BURST_W-1:0] start,
    // Result
    output logic [`FTS_BURST_W-1:0] offset
);

    // ------------------------------------------------------------
    // Offset arithmetic
    // ------------------------------------------------------------
    function automatic logic [`FTS_BURST_W-1:0] burst_offset(
        input logic lin,
        input logic [`FTS_BURST_W-1:0] st,
        input logic [`FTS_BURST_W-1:0] cnt
    );
        logic [`FTS_BURST_W-1:0] sum;
        sum = st + cnt;
        burst_offset = lin ? sum : (st ^ cnt);
    endfunction

    logic [`FTS_BURST_W-1:0] start_r;
    logic [`FTS_BURST_W-1:0] start_nxt;
    logic [`FTS_BURST_W-1:0] count_r;
    logic [`FTS_BURST_W-1:0] count_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign start_nxt = load ? start : start_r;
    assign count_nxt = load ? `FTS_BURST_START :
                       step ? count_r + `FTS_BURST_ONE : count_r;
    assign offset = burst_offset(linear, start_r, count_r);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            start_r <= `FTS_BURST_START;
            count_r <= `FTS_BURST_START;
        end
        else
        begin
            start_r <= start_nxt;
            count_r <= count_nxt;
        end
    end

endmodule

`default_nettype wire

/* core/fts_sram_port.sv */
// Purpose: Flow-through synchronous burst SRAM port with zero turnaround
// Assumes: All pins but arst_n synchronous to mclk; memory contents are not reset
// Notes: ORG_X18 selects the 18-bit organisation, else 36-bit
`default_nettype none
`include "fts_regs.svh"

module fts_sram_port
    import fts_pkg::*;
#(
    parameter bit ORG_X18 = 1'b0
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Address and burst control
    input wire logic [`FTS_ADDR_W-1:0] addr,
    input wire logic step_or_reload,
    input wire logic burst_linear,
    // Command
    input wire logic clock_qualify_n,
    input wire logic write_n,
    input wire logic [`FTS_LANES-1:0] byte_lane_write_n,
    // Chip selects
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    // Output drive and power
    input wire logic out_enable_n,
    input wire logic sleep_request,
    // Data bus
    input wire logic [`FTS_DATA_W-1:0] dq_in,
    output logic [`FTS_DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Status
    output logic low_power
);

    // ------------------------------------------------------------
    // Lane merge for one 18-bit half
    // ------------------------------------------------------------
    function automatic logic [`FTS_HALF_W-1:0] lane_merge(
        input logic [`FTS_HALF_W-1:0] old_word,
        input logic [`FTS_HALF_W-1:0] new_word,
        input logic [1:0] bw_n
    );
        logic [`FTS_HALF_W-1:0] res;
        res = old_word;
        if (!bw_n[0])
        begin
            res[`FTS_LANE_W-1:0] = new_word[`FTS_LANE_W-1:0];
        end
        if (!bw_n[1])
        begin
            res[`FTS_HALF_W-1:`FTS_LANE_W] = new_word[`FTS_HALF_W-1:`FTS_LANE_W];
        end
        lane_merge = res;
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [`FTS_HALF_W-1:0] mem_lo [`FTS_LO_DEPTH];
    logic [`FTS_HALF_W-1:0] mem_hi [`FTS_HI_DEPTH];

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fts_acc_t acc_r;
    fts_acc_t acc_nxt;
    fts_req_t req;
    wire qual;
    wire chip_selected;
    wire new_access;
    wire cont_access;
    wire ctr_load;
    wire ctr_step;
    wire [`FTS_BURST_W-1:0] burst_off;
    wire [`FTS_ADDR_W-1:0] cur_addr;
    wire [`FTS_ADDR_W-1:0] lo_idx;
    wire [`FTS_ADDR36_W-1:0] hi_idx;
    wire [`FTS_HALF_W-1:0] rd_lo;
    wire [`FTS_HALF_W-1:0] rd_hi;
    wire [`FTS_DATA_W-1:0] rd_word;
    wire [`FTS_LANES-1:0] lane_mask_n;
    wire is_read;
    wire is_write;
    wire do_write;
    wire [`FTS_HALF_W-1:0] wr_lo;
    wire [`FTS_HALF_W-1:0] wr_hi;

    // ------------------------------------------------------------
    // Request sampling
    // ------------------------------------------------------------
    assign qual = ~clock_qualify_n;
    assign chip_selected = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
    assign lane_mask_n = ORG_X18 ? {2'h3, byte_lane_write_n[1:0]} : byte_lane_write_n;

    always_comb
    begin
        req.addr = addr;
        req.we_n = write_n;
        req.bw_n = lane_mask_n;
        req.load = ~step_or_reload;
        req.sel = chip_selected & ~sleep_request;
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign new_access = qual & req.load & req.sel;
    assign cont_access = qual & ~req.load & (acc_r.op != FTS_OP_IDLE) & ~sleep_request;
    assign ctr_load = qual & req.load;
    assign ctr_step = cont_access;

    // ------------------------------------------------------------
    // Next access state
    // ------------------------------------------------------------
    always_comb
    begin
        acc_nxt = acc_r;
        if (qual)
        begin
            if (req.load)
            begin
                if (req.sel)
                begin
                    acc_nxt.op = req.we_n ? FTS_OP_READ : FTS_OP_WRITE;
                    acc_nxt.base = req.addr;
                    acc_nxt.bw_n = req.bw_n;
                end
                else
                begin
                    acc_nxt.op = FTS_OP_IDLE;
                    acc_nxt.bw_n = `FTS_BW_RST;
                end
            end
            else if (cont_access)
            begin
                acc_nxt.bw_n = req.bw_n;
            end
            else
            begin
                acc_nxt.op = FTS_OP_IDLE;
                acc_nxt.bw_n = `FTS_BW_RST;
            end
        end
    end

    // ------------------------------------------------------------
    // Access state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_r.op <= FTS_OP_IDLE;
            acc_r.base <= `FTS_ADDR_RST;
            acc_r.bw_n <= `FTS_BW_RST;
        end
        else
        begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Burst address
    // ------------------------------------------------------------
    fts_burst_ctr u_burst
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .load(ctr_load),
        .step(ctr_step),
        .linear(burst_linear),
        .start(req.addr[`FTS_BURST_W-1:0]),
        .offset(burst_off)
    );

    assign cur_addr = {acc_r.base[`FTS_ADDR_W-1:`FTS_BURST_W], burst_off};
    assign lo_idx = ORG_X18 ? cur_addr : {1'b0, cur_addr[`FTS_ADDR36_W-1:0]};
    assign hi_idx = cur_addr[`FTS_ADDR36_W-1:0];

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    always_comb
    begin
        case (acc_r.op)
            FTS_OP_IDLE:
            begin
                low_power = 1'b1;
            end
            FTS_OP_READ:
            begin
                low_power = sleep_request;
            end
            FTS_OP_WRITE:
            begin
                low_power = sleep_request;
            end
            default:
            begin
                low_power = 1'b1;
            end
        endcase
    end

    assign is_read = (acc_r.op == FTS_OP_READ);
    assign is_write = (acc_r.op == FTS_OP_WRITE);

    // ------------------------------------------------------------
    // Self-timed write, data one qualified cycle after command
    // ------------------------------------------------------------
    assign do_write = qual & is_write;
    assign wr_lo = lane_merge(mem_lo[lo_idx], dq_in[`FTS_HALF_W-1:0], acc_r.bw_n[1:0]);
    assign wr_hi = lane_merge(mem_hi[hi_idx], dq_in[`FTS_DATA_W-1:`FTS_HALF_W],
                              acc_r.bw_n[3:2]);

    always_ff @(posedge mclk)
    begin
        if (do_write)
        begin
            mem_lo[lo_idx] <= wr_lo;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (do_write && !ORG_X18)
        begin
            mem_hi[hi_idx] <= wr_hi;
        end
    end

    // ------------------------------------------------------------
    // Flow-through read path
    // ------------------------------------------------------------
    assign rd_lo = mem_lo[lo_idx];
    assign rd_hi = ORG_X18 ? {`FTS_HALF_W{1'b0}} : mem_hi[hi_idx];
    assign rd_word = {rd_hi, rd_lo};
    assign dq_out = is_read ? rd_word : {`FTS_DATA_W{1'b0}};

    // ------------------------------------------------------------
    // Output drive control
    // ------------------------------------------------------------
    assign dq_oe = is_read & ~out_enable_n & ~sleep_request;

endmodule

`default_nettype wire

/* test/fts_sram_port_assertions.sv */
// Purpose: Port-level checks on the flow-through SRAM port
// Assumes: Bound to fts_sram_port, x36 or x18
// Notes: Single clock domain
`default_nettype none
`include "fts_regs.svh"

module fts_sram_port_checker
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request pins
    input wire logic step_or_reload,
    input wire logic clock_qualify_n,
    input wire logic write_n,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    // Outputs
    input wire logic [`FTS_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic low_power
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic qual;
    wire logic sel;
    wire logic rd;
    wire logic wr;
    assign qual = !clock_qualify_n;
    assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    assign rd = qual && !step_or_reload && sel && !sleep_request && write_n;
    assign wr = qual && !step_or_reload && sel && !sleep_request && !write_n;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_oe;
        dq_oe |-> !out_enable_n && !sleep_request;
    endproperty
    a_oe: assert property (p_oe) else $error("drive without enable");
    property p_slp;
        sleep_request |-> low_power && !dq_oe;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep not honoured");
    property p_hold;
        clock_qualify_n && !sleep_request |=> $stable(dq_out) || sleep_request;
    endproperty
    a_hold: assert property (p_hold) else $error("state moved in stall");
    property p_wr_tri;
        wr |=> !dq_oe;
    endproperty
    a_wr_tri: assert property (p_wr_tri) else $error("drive in write");
    property p_rd_oe;
        rd |=> dq_oe || out_enable_n || sleep_request;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read not driven");
    property p_wr_to_rd;
        wr ##1 rd |=> dq_oe || out_enable_n || sleep_request;
    endproperty
    a_wr_to_rd: assert property (p_wr_to_rd) else $error("turnaround gap");
    property p_desel;
        qual && !step_or_reload && !sel |=> !dq_oe && low_power;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect ignored");
    property p_lp;
        rd |=> !low_power || sleep_request;
    endproperty
    a_lp: assert property (p_lp) else $error("low power in read");
    property p_step_idle;
        qual && step_or_reload && low_power |=> low_power;
    endproperty
    a_step_idle: assert property (p_step_idle) else $error("step left idle");
endmodule

bind fts_sram_port fts_sram_port_checker u_fts_sram_port_checker (.mclk, .arst_n,
    .step_or_reload, .clock_qualify_n, .write_n, .chip_sel1_n, .chip_sel2, .chip_sel3_n,
    .out_enable_n, .sleep_request, .dq_out, .dq_oe, .low_power);

`default_nettype wire

/* test/fts_ctrl_model.sv */
// Purpose: Controller driving the SRAM port pins
// Assumes: Tasks called from the bench
// Notes: beat and stall changes land on the rising edge; cfg changes apply at once
`default_nettype none
`include "fts_regs.svh"

module fts_ctrl_model
(
    // Clock
    input wire logic mclk,
    // Request pins
    output var logic [`FTS_ADDR_W-1:0] addr,
    output var logic step_or_reload,
    output var logic burst_linear,
    output var logic clock_qualify_n,
    output var logic write_n,
    output var logic [`FTS_LANES-1:0] byte_lane_write_n,
    output var logic chip_sel1_n,
    output var logic chip_sel2,
    output var logic chip_sel3_n,
    output var logic out_enable_n,
    output var logic sleep_request,
    output var logic [`FTS_DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {addr, step_or_reload, burst_linear, clock_qualify_n, write_n} = '0;
        byte_lane_write_n = 4'hf;
        {chip_sel1_n, chip_sel2, chip_sel3_n} = 3'h0;
        {out_enable_n, sleep_request} = 2'h0;
        dq_in = '0;
    end

    // One qualified beat
    task automatic beat(input logic ld, input logic wr, input logic [2:0] cs,
        input logic [`FTS_ADDR_W-1:0] a, input logic [`FTS_LANES-1:0] bw,
        input logic [`FTS_DATA_W-1:0] d);
        @(posedge mclk);
        clock_qualify_n <= 1'b0;
        step_or_reload <= !ld;
        write_n <= !wr;
        byte_lane_write_n <= bw;
        {chip_sel1_n, chip_sel2, chip_sel3_n} <= cs;
        addr <= a;
        dq_in <= d;
        #1;
    endtask

    // Stall with the bus held
    task automatic stall(input int n);
        repeat (n) @(posedge mclk) clock_qualify_n <= 1'b1;
        #1;
    endtask

    task automatic cfg(input logic lin, input logic oe_n, input logic slp);
        burst_linear <= lin;
        out_enable_n <= oe_n;
        sleep_request <= slp;
    endtask
endmodule

`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench for the flow-through SRAM port
// Assumes: x36 organisation
// Notes: Outputs after a beat show the previous beat
`default_nettype none
`include "fts_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk;
    logic arst_n;
    logic [`FTS_ADDR_W-1:0] addr;
    logic step_or_reload, burst_linear, clock_qualify_n, write_n;
    logic [`FTS_LANES-1:0] byte_lane_write_n;
    logic chip_sel1_n, chip_sel2, chip_sel3_n, out_enable_n, sleep_request;
    logic [`FTS_DATA_W-1:0] dq_in;
    logic [`FTS_DATA_W-1:0] dq_out;
    logic dq_oe, low_power;
    int mismatches = 0;
    int n_compared = 0;
    localparam logic [2:0] ON = 3'h2;
    localparam logic [35:0] DB = 36'h123450000;
    localparam logic [35:0] M = 36'h007fc01ff;

    fts_ctrl_model u_fts_ctrl_model (.*);
    fts_sram_port u_fts_sram_port (.*);

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bt(input logic ld, input logic wr, input logic [2:0] cs,
        input logic [19:0] a, input logic [3:0] bw, input logic [35:0] d);
        u_fts_ctrl_model.beat(ld, wr, cs, a, bw, d);
    endtask

    task automatic t_wr_rd;
        bt(1'b1, 1'b1, ON, 20'h00100, 4'h0, ~DB);
        bt(1'b1, 1'b0, ON, 20'h00100, 4'hf, DB);
        check({35'h0, dq_oe}, 36'h0);
        bt(1'b1, 1'b0, 3'h0, 20'h00100, 4'hf, ~DB);
        check(dq_out, DB);
        check({35'h0, dq_oe}, 36'h1);
    endtask

    task automatic t_lanes;
        bt(1'b1, 1'b1, ON, 20'h00104, 4'h0, ~DB);
        bt(1'b1, 1'b1, ON, 20'h00104, 4'ha, DB);
        bt(1'b1, 1'b0, ON, 20'h00104, 4'hf, ~DB);
        bt(1'b1, 1'b0, 3'h0, 20'h00104, 4'hf, DB);
        check(dq_out, (~DB & M) | (DB & ~M));
    endtask

    task automatic t_burst(input logic lin);
        logic [1:0] off;
        u_fts_ctrl_model.cfg(lin, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++)
            bt(i == 0 || i == 4, i < 4, ON, i < 4 ? 20'h00200 : 20'h00201, 4'h0, DB + i - 1);
        for (int i = 0; i < 4; i++)
        begin
            bt(i == 3, 1'b0, i == 3 ? 3'h0 : ON, 20'h00200, 4'hf, ~DB);
            off = lin ? 2'h1 + i[1:0] : 2'h1 ^ i[1:0];
            check(dq_out, DB + off);
        end
    endtask

    task automatic t_stall;
        u_fts_ctrl_model.cfg(1'b1, 1'b0, 1'b0);
        bt(1'b1, 1'b0, ON, 20'h00200, 4'hf, ~DB);
        u_fts_ctrl_model.stall(3);
        check(dq_out, DB);
        bt(1'b0, 1'b0, ON, 20'h00200, 4'hf, ~DB);
        check(dq_out, DB);
        bt(1'b1, 1'b0, 3'h0, 20'h00200, 4'hf, ~DB);
        check(dq_out, DB + 36'h1);
    endtask

    task automatic t_desel;
        for (int k = 0; k < 3; k++)
        begin
            bt(1'b1, 1'b0, ON ^ (3'h1 << k), 20'h00200, 4'hf, DB);
            bt(1'b0, 1'b0, ON, 20'h00200, 4'hf, ~DB);
            check({34'h0, dq_oe, low_power}, 36'h1);
            bt(1'b1, 1'b0, 3'h0, 20'h00200, 4'hf, DB);
            check({34'h0, dq_oe, low_power}, 36'h1);
        end
        bt(1'b1, 1'b0, ON, 20'h00200, 4'hf, DB);
        bt(1'b0, 1'b0, ON, 20'h00200, 4'hf, ~DB);
        check({34'h0, dq_oe, low_power}, 36'h2);
        u_fts_ctrl_model.cfg(1'b1, 1'b1, 1'b0);
        #1 check({34'h0, dq_oe, low_power}, 36'h0);
        u_fts_ctrl_model.cfg(1'b1, 1'b0, 1'b1);
        #1 check({34'h0, dq_oe, low_power}, 36'h1);
        bt(1'b1, 1'b0, 3'h0, 20'h00200, 4'hf, DB);
        check({34'h0, dq_oe, low_power}, 36'h1);
        u_fts_ctrl_model.cfg(1'b1, 1'b0, 1'b0);
    endtask

    initial
    begin
        arst_n = 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        t_wr_rd();
        t_lanes();
        t_burst(1'b1);
        t_burst(1'b0);
        t_stall();
        t_desel();
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
endmodule

`default_nettype wire
